// ==== src/tpf_consts.svh ====
`ifndef TPF_CONSTS_SVH
`define TPF_CONSTS_SVH

// ==========================================================
// rtp header fields
`define TPF_RTP_VERSION 2'h2
`define TPF_RTP_ZERO_FLAGS 1'h0
`define TPF_RTP_ZERO_CC 4'h0
`define TPF_PT_DYN_LO 7'h60
`define TPF_PT_DYN_HI 7'h7F

// ==========================================================
// oam fields
`define TPF_OAM_NIBBLE 4'h1
`define TPF_FORMAT_IDENTIFIER_NIBBLE_ZERO 4'h0
`define TPF_RES_ZERO 8'h00
`define TPF_VCCV_CHAN_TYPE 16'h0000
`define TPF_OAM_TYPE_QUERY 8'h00
`define TPF_OAM_TYPE_REPLY 8'h08
`define TPF_OAM_BASE_LEN 16'h0010
`define TPF_OAM_TS_LEN 16'h000C
`define TPF_SEQ_RESET 16'h0000
`define TPF_TS_RESET 32'h00000000

// ==========================================================
// timing
`define TPF_CLK_NS 50
`define TPF_FINE_RES_NS 1000
`define TPF_COARSE_RES_NS 100000
`define TPF_FINE_CYCLES (`TPF_FINE_RES_NS / `TPF_CLK_NS)
`define TPF_COARSE_CYCLES (`TPF_COARSE_RES_NS / `TPF_CLK_NS)

`endif

// ==== src/tpf_pkg.sv ====
package tpf_pkg;
	typedef enum logic [1:0] {
		TPF_KIND_AAL1,
		TPF_KIND_HDLC,
		TPF_KIND_RAW,
		TPF_KIND_OAM
	} tpf_kind_t;

	typedef enum logic {
		TPF_TS_ABSOLUTE,
		TPF_TS_DIFFERENTIAL
	} tpf_ts_mode_t;

	typedef logic [15:0] tpf_bundle_t;
endpackage : tpf_pkg

// ==== src/tpf_framer.sv ====
`timescale 1ns/1ps
`include "tpf_consts.svh"
module tpf_framer
	import tpf_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic TX_START,
	input wire logic [1:0] TX_KIND,
	input wire logic [15:0] TX_CW_SEQ,
	input wire logic [6:0] TX_PT,
	input wire logic [31:0] TX_SSRC,
	input wire logic [15:0] TX_BUNDLE,
	input wire logic TS_MODE,
	input wire logic TDM_FRAME_TICK,
	input wire logic NET_CLK_TICK,
	input wire logic VCCV_START,
	input wire logic OAM_QUERY_START,
	input wire logic OAM_QUERY_NO_VALIDATE,
	input wire logic OAM_REPLY_START,
	input wire logic OAM_REPLY_MISMATCH,
	input wire logic [15:0] OAM_REPLY_SEQ,
	input wire logic [2:0] OAM_LIST_SEL,
	input wire logic OAM_DELAY_MEASURE,
	input wire logic TS_RES_FINE,
	input wire logic BUNDLE_L,
	input wire logic BUNDLE_R,
	input wire logic [1:0] BUNDLE_M,
	input wire logic LIST_WR,
	input wire logic [2:0] LIST_WR_IDX,
	input wire logic [15:0] LIST_WR_DATA,
	input wire logic LIST_WR_VALID,
	input wire logic RX_START,
	input wire logic [3:0] RX_NIBBLE,
	input wire logic [15:0] RX_BUNDLE,
	input wire logic RX_REPLY,
	input wire logic [15:0] RX_REPLY_SEQ,
	output logic [95:0] RTP_HDR,
	output logic RTP_VALID,
	output logic [1:0] TX_KIND_OUT,
	output logic [15:0] TX_HDR_BUNDLE,
	output logic PT_ILLEGAL,
	output logic [31:0] VCCV_HDR,
	output logic [15:0] VCCV_BUNDLE,
	output logic VCCV_VALID,
	output logic OAM_TX_VALID,
	output logic [15:0] OAM_TX_BUNDLE,
	output logic OAM_TX_BUNDLE_OK,
	output logic [3:0] OAM_TX_FLAGS,
	output logic [15:0] OAM_TX_LEN,
	output logic [15:0] OAM_TX_SEQ,
	output logic [7:0] OAM_TX_TYPE,
	output logic [7:0] OAM_TX_CODE,
	output logic OAM_TX_TS_PRESENT,
	output logic [31:0] OAM_TX_TS,
	output logic RX_TO_OAM,
	output logic RX_TO_CW,
	output logic RX_OAM_LISTED,
	output logic REPLY_MATCH,
	output logic REPLY_MISMATCH
);

	// ==========================================================
	// helpers
	function automatic logic pt_dynamic(input logic [6:0] pt);
		pt_dynamic = (pt >= `TPF_PT_DYN_LO) && (pt <= `TPF_PT_DYN_HI);
	endfunction : pt_dynamic

	localparam int FINE_CYC = `TPF_FINE_CYCLES;
	localparam int COARSE_CYC = `TPF_COARSE_CYCLES;
	localparam logic [10:0] FINE_LAST = 11'(FINE_CYC - 1);
	localparam logic [10:0] COARSE_LAST = 11'(COARSE_CYC - 1);

	// ==========================================================
	// rtp timestamp
	logic [31:0] rtp_ts;
	logic [31:0] next_rtp_ts;
	wire tpf_ts_mode_t ts_mode = tpf_ts_mode_t'(TS_MODE);
	// absolute mode only moves on a tdm frame, so it tracks the circuit clock, not ours
	wire ts_abs_step = (ts_mode == TPF_TS_ABSOLUTE) && TDM_FRAME_TICK;
	wire ts_diff_step = (ts_mode == TPF_TS_DIFFERENTIAL) && NET_CLK_TICK;
	wire ts_step = ts_abs_step || ts_diff_step;

	assign next_rtp_ts = ts_step ? rtp_ts + 32'h00000001 : rtp_ts;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rtp_ts <= `TPF_TS_RESET;
		end else begin
			rtp_ts <= next_rtp_ts;
		end
	end

	// ==========================================================
	// rtp header build
	wire logic [1:0] rtp_ver = `TPF_RTP_VERSION;
	wire logic rtp_pad = `TPF_RTP_ZERO_FLAGS;
	wire logic rtp_ext = `TPF_RTP_ZERO_FLAGS;
	wire logic [3:0] rtp_cc = `TPF_RTP_ZERO_CC;
	wire logic rtp_mark = `TPF_RTP_ZERO_FLAGS;
	// sequence is the control word's own value, never a separate counter
	wire logic [95:0] next_rtp_hdr = {rtp_ver, rtp_pad, rtp_ext, rtp_cc, rtp_mark, TX_PT,
		TX_CW_SEQ, next_rtp_ts, TX_SSRC};
	wire tpf_kind_t tx_kind = tpf_kind_t'(TX_KIND);
	// the pt is software's choice; flag it rather than rewrite it
	wire next_pt_illegal = !pt_dynamic(TX_PT);

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			RTP_VALID <= 1'b0;
		end else begin
			RTP_VALID <= TX_START;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			PT_ILLEGAL <= 1'b0;
		end else begin
			PT_ILLEGAL <= next_pt_illegal;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			RTP_HDR <= 96'h0;
			TX_KIND_OUT <= 2'h0;
			TX_HDR_BUNDLE <= 16'h0000;
		end else if (TX_START) begin
			RTP_HDR <= next_rtp_hdr;
			TX_KIND_OUT <= 2'(tx_kind);
			TX_HDR_BUNDLE <= TX_BUNDLE;
		end
	end

	// ==========================================================
	// vccv oam header
	// the caller reuses the data encapsulation; only the bundle is echoed here
	wire logic [31:0] next_vccv_hdr = {`TPF_OAM_NIBBLE, `TPF_FORMAT_IDENTIFIER_NIBBLE_ZERO, `TPF_RES_ZERO,
		`TPF_VCCV_CHAN_TYPE};

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			VCCV_VALID <= 1'b0;
		end else begin
			VCCV_VALID <= VCCV_START;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			VCCV_HDR <= 32'h00000000;
			VCCV_BUNDLE <= 16'h0000;
		end else if (VCCV_START) begin
			VCCV_HDR <= next_vccv_hdr;
			VCCV_BUNDLE <= TX_BUNDLE;
		end
	end

	// ==========================================================
	// maintenance bundle id list
	tpf_bundle_t list_id [8];
	logic [7:0] list_ok;
	logic [7:0] rx_hit;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_list
			always_ff @(posedge CLK) begin
				if (!RESET_N) begin
					list_id[gi] <= 16'h0000;
					list_ok[gi] <= 1'b0;
				end else if (LIST_WR && (LIST_WR_IDX == 3'(gi))) begin
					list_id[gi] <= LIST_WR_DATA;
					list_ok[gi] <= LIST_WR_VALID;
				end
			end
			assign rx_hit[gi] = list_ok[gi] && (list_id[gi] == RX_BUNDLE);
		end
	endgenerate

	// ==========================================================
	// delay timestamp timebase
	logic [10:0] res_cnt;
	logic [31:0] oam_ts;
	wire [10:0] res_last = TS_RES_FINE ? FINE_LAST : COARSE_LAST;
	// at or above, so a switch from coarse to fine never waits for the counter to wrap
	wire res_tick = (res_cnt >= res_last);
	wire [10:0] next_res_cnt = res_tick ? 11'h000 : res_cnt + 11'h001;
	wire [31:0] next_oam_ts = res_tick ? oam_ts + 32'h00000001 : oam_ts;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			res_cnt <= 11'h000;
			oam_ts <= `TPF_TS_RESET;
		end else begin
			res_cnt <= next_res_cnt;
			oam_ts <= next_oam_ts;
		end
	end

	// ==========================================================
	// udp oam transmit
	logic [15:0] oam_seq;
	// reply wins if both ask at once; a query retried next cycle costs nothing
	wire oam_go = OAM_QUERY_START || OAM_REPLY_START;
	wire is_reply = OAM_REPLY_START;
	wire [15:0] next_oam_seq = (OAM_QUERY_START && !is_reply) ?
		oam_seq + 16'h0001 : oam_seq;
	wire [15:0] tx_seq = is_reply ? OAM_REPLY_SEQ : next_oam_seq;
	wire [7:0] tx_type = is_reply ? `TPF_OAM_TYPE_REPLY : `TPF_OAM_TYPE_QUERY;
	wire [7:0] tx_code_q = {7'h00, OAM_QUERY_NO_VALIDATE};
	wire [7:0] tx_code_r = {7'h00, OAM_REPLY_MISMATCH};
	wire [7:0] tx_code = is_reply ? tx_code_r : tx_code_q;
	wire [15:0] tx_len = OAM_DELAY_MEASURE ?
		`TPF_OAM_BASE_LEN + `TPF_OAM_TS_LEN : `TPF_OAM_BASE_LEN;
	wire [15:0] tx_oam_bundle = list_id[OAM_LIST_SEL];
	wire tx_oam_ok = list_ok[OAM_LIST_SEL];

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			oam_seq <= `TPF_SEQ_RESET;
		end else begin
			oam_seq <= next_oam_seq;
		end
	end

	// pulse only for a listed bundle, so no packet leaves under an unknown id
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			OAM_TX_VALID <= 1'b0;
		end else begin
			OAM_TX_VALID <= oam_go && tx_oam_ok;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			OAM_TX_BUNDLE <= 16'h0000;
			OAM_TX_BUNDLE_OK <= 1'b0;
		end else if (oam_go) begin
			OAM_TX_BUNDLE <= tx_oam_bundle;
			OAM_TX_BUNDLE_OK <= tx_oam_ok;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			OAM_TX_FLAGS <= 4'h0;
			OAM_TX_LEN <= 16'h0000;
		end else if (oam_go) begin
			OAM_TX_FLAGS <= {BUNDLE_L, BUNDLE_R, BUNDLE_M};
			OAM_TX_LEN <= tx_len;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			OAM_TX_SEQ <= 16'h0000;
			OAM_TX_TYPE <= 8'h00;
			OAM_TX_CODE <= 8'h00;
		end else if (oam_go) begin
			OAM_TX_SEQ <= tx_seq;
			OAM_TX_TYPE <= tx_type;
			OAM_TX_CODE <= tx_code;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			OAM_TX_TS_PRESENT <= 1'b0;
			OAM_TX_TS <= 32'h00000000;
		end else if (oam_go) begin
			OAM_TX_TS_PRESENT <= OAM_DELAY_MEASURE;
			OAM_TX_TS <= OAM_DELAY_MEASURE ? oam_ts : 32'h00000000;
		end
	end

	// ==========================================================
	// receive classification
	// decided on the nibble alone so control word logic never sees oam
	wire rx_is_oam = (RX_NIBBLE == `TPF_OAM_NIBBLE);

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			RX_TO_OAM <= 1'b0;
		end else begin
			RX_TO_OAM <= RX_START && rx_is_oam;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			RX_TO_CW <= 1'b0;
		end else begin
			RX_TO_CW <= RX_START && !rx_is_oam;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			RX_OAM_LISTED <= 1'b0;
		end else begin
			RX_OAM_LISTED <= RX_START && (|rx_hit);
		end
	end

	// ==========================================================
	// reply matching
	// only the latest query is tracked; an older reply counts as a mismatch
	wire reply_eq = (RX_REPLY_SEQ == oam_seq);

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			REPLY_MATCH <= 1'b0;
		end else begin
			REPLY_MATCH <= RX_REPLY && reply_eq;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			REPLY_MISMATCH <= 1'b0;
		end else begin
			REPLY_MISMATCH <= RX_REPLY && !reply_eq;
		end
	end

endmodule : tpf_framer

// ==== testbench/tpf_framer_props.sv ====
`timescale 1ns/1ps
// ==========
// port checks
module tpf_framer_props (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic TX_START,
	input wire logic [15:0] TX_CW_SEQ,
	input wire logic VCCV_START,
	input wire logic RX_START,
	input wire logic [3:0] RX_NIBBLE,
	input wire logic OAM_QUERY_START,
	input wire logic OAM_REPLY_START,
	input wire logic [15:0] OAM_REPLY_SEQ,
	input wire logic RX_REPLY,
	input wire logic [95:0] RTP_HDR,
	input wire logic RTP_VALID,
	input wire logic [31:0] VCCV_HDR,
	input wire logic VCCV_VALID,
	input wire logic RX_TO_OAM,
	input wire logic RX_TO_CW,
	input wire logic [15:0] OAM_TX_SEQ,
	input wire logic [7:0] OAM_TX_TYPE,
	input wire logic REPLY_MATCH,
	input wire logic REPLY_MISMATCH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_ver; RTP_VALID |-> RTP_HDR[95:94] == 2'h2; endproperty
	a_ver: assert property (p_ver) else $error("version");
	property p_zero; RTP_VALID |-> RTP_HDR[93:87] == 7'h00; endproperty
	a_zero: assert property (p_zero) else $error("flags");
	property p_sn; TX_START |=> RTP_VALID && RTP_HDR[79:64] == $past(TX_CW_SEQ); endproperty
	a_sn: assert property (p_sn) else $error("rtp seq");
	property p_vccv; VCCV_START |=> VCCV_VALID && VCCV_HDR[31:16] == 16'h1000; endproperty
	a_vccv: assert property (p_vccv) else $error("vccv");
	property p_rx;
		RX_START |=> RX_TO_OAM == ($past(RX_NIBBLE) == 4'h1) && RX_TO_CW != RX_TO_OAM;
	endproperty
	a_rx: assert property (p_rx) else $error("rx divert");
	property p_rep;
		OAM_REPLY_START |=> OAM_TX_TYPE == 8'h08 && OAM_TX_SEQ == $past(OAM_REPLY_SEQ);
	endproperty
	a_rep: assert property (p_rep) else $error("reply");
	property p_qry; OAM_QUERY_START && !OAM_REPLY_START |=> OAM_TX_TYPE == 8'h00; endproperty
	a_qry: assert property (p_qry) else $error("query");
	property p_match; RX_REPLY |=> REPLY_MATCH != REPLY_MISMATCH; endproperty
	a_match: assert property (p_match) else $error("match");
	c_rtp: cover property (TX_START ##1 RTP_VALID);
	c_oam: cover property (RX_TO_OAM);
	c_hit: cover property (REPLY_MATCH);
endmodule : tpf_framer_props
bind tpf_framer tpf_framer_props u_props (.*);

// ==== testbench/tpf_gateway_model.sv ====
`timescale 1ns/1ps
// ==========
// far gateway: answers each query
module tpf_gateway_model (
	input wire logic clk,
	input wire logic q_valid,
	input wire logic [7:0] q_type,
	input wire logic [15:0] q_seq,
	input wire logic bad,
	output logic reply = 1'h0,
	output logic [15:0] reply_seq = 16'h0000
);
	// idle seq flips every cycle so a stale value never matches
	always @(posedge clk) begin
		reply <= q_valid && q_type == 8'h00;
		reply_seq <= q_valid ? q_seq ^ {15'h0000, bad} : ~reply_seq;
	end
endmodule : tpf_gateway_model

// ==== testbench/tb_tpf_framer.sv ====
`timescale 1ns/1ps
`include "tpf_consts.svh"
// ==========
// random traffic against a cycle model
module tb_tpf_framer;
	logic CLK = 0, RESET_N = 0, TX_START = 0, TS_MODE = 0, TDM_FRAME_TICK = 0, NET_CLK_TICK = 0;
	logic VCCV_START = 0, OAM_QUERY_START = 0, OAM_QUERY_NO_VALIDATE = 0, OAM_REPLY_START = 0;
	logic OAM_REPLY_MISMATCH = 0, OAM_DELAY_MEASURE = 0, TS_RES_FINE = 0, BUNDLE_L = 0;
	logic BUNDLE_R = 0, LIST_WR = 0, LIST_WR_VALID = 0, RX_START = 0, bad = 0;
	logic [1:0] TX_KIND = 0, BUNDLE_M = 0, TX_KIND_OUT;
	logic [2:0] OAM_LIST_SEL = 0, LIST_WR_IDX = 0;
	logic [3:0] RX_NIBBLE = 0, OAM_TX_FLAGS;
	logic [6:0] TX_PT = 0;
	logic [15:0] TX_CW_SEQ = 0, TX_BUNDLE = 0, OAM_REPLY_SEQ = 0, LIST_WR_DATA = 0, RX_BUNDLE = 0;
	logic [31:0] TX_SSRC = 0, VCCV_HDR, OAM_TX_TS, r, q;
	logic RX_REPLY, RTP_VALID, PT_ILLEGAL, VCCV_VALID, OAM_TX_VALID, OAM_TX_BUNDLE_OK, hit, b;
	logic OAM_TX_TS_PRESENT, RX_TO_OAM, RX_TO_CW, RX_OAM_LISTED, REPLY_MATCH, REPLY_MISMATCH;
	logic [7:0] OAM_TX_TYPE, OAM_TX_CODE;
	logic [15:0] RX_REPLY_SEQ, TX_HDR_BUNDLE, VCCV_BUNDLE, OAM_TX_BUNDLE, OAM_TX_LEN, OAM_TX_SEQ;
	logic [95:0] RTP_HDR;
	// ==========
	// model state
	logic [97:0] e_rtp = 0;
	logic [47:0] e_v = 0;
	logic [31:0] e_os = 0;
	logic [20:0] e_of = 0;
	logic [4:0] e_p = 0;
	logic [2:0] e_rx = 0;
	logic [1:0] e_rm = 0;
	logic [15:0] e_ob = 0, e_hb = 0;
	logic [31:0] e_ts = 0;
	int mrc = 0, mts = 0;
	logic [15:0] lv[8] = '{default: 0};
	logic lo[8] = '{default: 0};
	bit pq[$];
	int ts = 0, oseq = 0, seed = 16, err_count = 0, comparisons = 0, i, j;
	tpf_framer dut (.*);
	tpf_gateway_model gw (.clk(CLK), .q_valid(OAM_TX_VALID), .q_type(OAM_TX_TYPE),
		.q_seq(OAM_TX_SEQ), .bad(bad), .reply(RX_REPLY), .reply_seq(RX_REPLY_SEQ));
	always #25 CLK = ~CLK;
	// delay timebase model: one step per resolution period
	always @(posedge CLK) begin
		if (!RESET_N) begin
			mrc = 0;
			mts = 0;
		end else if (mrc >= (TS_RES_FINE ? `TPF_FINE_CYCLES : `TPF_COARSE_CYCLES) - 1) begin
			mrc = 0;
			mts++;
		end else
			mrc++;
	end
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge CLK);
		RESET_N <= 1'h1;
		@(posedge CLK);
		for (i = 0; i < 300; i++) begin
			@(posedge CLK);
			r = $random(seed);
			q = $random(seed);
			{TX_START, VCCV_START, RX_START, LIST_WR, LIST_WR_VALID, TDM_FRAME_TICK, NET_CLK_TICK,
				OAM_QUERY_NO_VALIDATE, OAM_REPLY_MISMATCH, OAM_DELAY_MEASURE, TS_RES_FINE,
				BUNDLE_L, BUNDLE_R, bad} <= r[13:0];
			{OAM_QUERY_START, OAM_REPLY_START} <= i[0] ? 2'h0 : r[15:14];
			{TX_KIND, BUNDLE_M, OAM_LIST_SEL, LIST_WR_IDX, TX_PT} <= q[16:0];
			RX_NIBBLE <= r[16] ? 4'h1 : r[20:17];
			LIST_WR_DATA <= {12'h000, r[24:21]};
			RX_BUNDLE <= {12'h000, r[28:25]};
			{TX_CW_SEQ, OAM_REPLY_SEQ} <= $random(seed);
			TX_SSRC <= $random(seed);
			TX_BUNDLE <= q[31:16];
			TS_MODE <= i >= 150;
			@(negedge CLK);
			e_rm = 2'h0;
			if (pq.size() > 0) begin
				b = pq.pop_front();
				e_rm = {!b, b};
			end
			if (TS_MODE ? NET_CLK_TICK : TDM_FRAME_TICK)
				ts++;
			hit = 0;
			for (j = 0; j < 8; j++)
				hit |= lo[j] && lv[j] == RX_BUNDLE;
			e_rx = {RX_START && RX_NIBBLE == 4'h1, RX_START && RX_NIBBLE != 4'h1, RX_START && hit};
			e_p = {TX_START, VCCV_START, (OAM_QUERY_START | OAM_REPLY_START) & lo[OAM_LIST_SEL],
				TX_PT < 7'h60, e_p[0]};
			if (TX_START) begin
				e_rtp = {2'h2, 7'h00, TX_PT, TX_CW_SEQ, ts[31:0], TX_SSRC, TX_KIND};
				e_hb = TX_BUNDLE;
			end
			if (VCCV_START)
				e_v = {`TPF_OAM_NIBBLE, `TPF_FORMAT_IDENTIFIER_NIBBLE_ZERO, `TPF_RES_ZERO, `TPF_VCCV_CHAN_TYPE, TX_BUNDLE};
			if (OAM_QUERY_START | OAM_REPLY_START) begin
				e_p[0] = lo[OAM_LIST_SEL];
				e_ob = lv[OAM_LIST_SEL];
				e_ts = OAM_DELAY_MEASURE ? mts : 0;
				e_of = {BUNDLE_L, BUNDLE_R, BUNDLE_M, OAM_DELAY_MEASURE ? 16'h001C : 16'h0010,
					OAM_DELAY_MEASURE};
				// a reply wins when both start together
				if (OAM_REPLY_START)
					e_os = {OAM_REPLY_SEQ, 8'h08, 7'h00, OAM_REPLY_MISMATCH};
				else begin
					oseq++;
					e_os = {oseq[15:0], 8'h00, 7'h00, OAM_QUERY_NO_VALIDATE};
					if (lo[OAM_LIST_SEL])
						pq.push_back(bad);
				end
			end
			if (LIST_WR) begin
				lv[LIST_WR_IDX] = LIST_WR_DATA;
				lo[LIST_WR_IDX] = LIST_WR_VALID;
			end
			@(posedge CLK);
			{TX_START, VCCV_START, RX_START, LIST_WR, TDM_FRAME_TICK, NET_CLK_TICK, OAM_QUERY_START,
				OAM_REPLY_START} <= 8'h00;
			@(negedge CLK);
			chk({RTP_HDR, TX_KIND_OUT} === e_rtp, "rtp");
			chk({RTP_VALID, VCCV_VALID, OAM_TX_VALID, PT_ILLEGAL} === e_p[4:1], "strobe");
			chk({VCCV_HDR, VCCV_BUNDLE} === e_v, "vccv");
			chk({RX_TO_OAM, RX_TO_CW, RX_OAM_LISTED} === e_rx, "rx");
			chk(OAM_TX_BUNDLE_OK === e_p[0], "list");
			chk({OAM_TX_FLAGS, OAM_TX_LEN, OAM_TX_TS_PRESENT} === e_of, "oam");
			chk(OAM_TX_TS === e_ts, "ts");
			chk(OAM_TX_BUNDLE === e_ob, "oam bundle");
			chk(TX_HDR_BUNDLE === e_hb, "hdr bundle");
			chk({OAM_TX_SEQ, OAM_TX_TYPE, OAM_TX_CODE} === e_os, "seq");
			chk({REPLY_MATCH, REPLY_MISMATCH} === e_rm, "reply");
		end
		give_verdict();
	end
endmodule : tb_tpf_framer
